/* File: verilog/sww_watchdog.sv */
// Secondary window watchdog: counter, prescaler, mode latch, status flags, fault.
// Assumes register strobes come synchronous to mclk; slowTick is a one-cycle slow clock pulse.
//
// Summary of operation
// - Twelve-bit down counter loaded from reload_value in the mode register.
// - Counter decrements once per 128 slow clock ticks.
// - Processor reset sets reload_value to all ones.
// - Power-on leaves watchdog disabled; processor reset restores all defaults.
// - Only the first mode write is taken until a processor reset.
// - Mode write reloads counter and restarts with new configuration.
// - Keyed restart inside the window reloads counter; every keyed restart restarts the prescaler.
// - Control writes with wrong key have no effect at all.
// - Underflow sets underflow_flag; fault output if fault_reset_enable.
// - Restart above delta_window_limit sets window_error_flag and fault, even disabled.
// - delta_window_limit at or above reload_value permits restart anywhere.
// - Interrupt when a flag is set and fault_irq_enable is set.
// - Fault with fault_reset_enable requests a reset clearing flags.
// - Status read or reset clears flags, interrupt and fault.
// - Counter freezes in debug with debug_stop, idle with idle_stop.
// - Slow RC used when main RC unused and crystal or primary off.
// - Only general or processor-only reset requests are produced.
// - processor_only_reset picks processor-only versus whole-system reset.
// - watchdog_off stops the counter.
`timescale 1ns/100ps
`default_nettype none
`include "sww_map.svh"
module sww_watchdog
#(
  parameter int CNT_W = `SWW_CNT_W
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic procRst,
  input wire logic slowTick,
  input wire logic ctrlWrite,
  input wire logic [31:0] ctrlData,
  input wire logic modeWrite,
  input wire logic [31:0] modeData,
  input wire logic statusRead,
  input wire logic debugState,
  input wire logic idleState,
  input wire logic main_rc_on,
  input wire logic crystal_select,
  input wire logic primaryOff,
  output logic [31:0] modeReg,
  output logic [1:0] statusReg,
  output logic [CNT_W-1:0] countValue,
  output logic faultIrq,
  output logic fault_to_reset_ctrl,
  output logic [1:0] resetKind,
  output logic useSlowRc,
  output logic useMainRc
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic modeTaken;
  logic keyOk;
  logic restartReq;
  logic inWindow;
  logic halted;
  logic tick;
  logic underflow;
  logic winError;
  logic [`SWW_PRE_W-1:0] prescale;
  logic [CNT_W-1:0] reloadValue;
  logic [CNT_W-1:0] deltaLimit;
  logic [1:0] next_status;

  assign reloadValue = modeReg[`SWW_MR_RELOAD_LSB +: CNT_W];
  assign deltaLimit = modeReg[`SWW_MR_DELTA_LSB +: CNT_W];
  assign keyOk = (ctrlData[`SWW_CR_KEY_LSB +: 8] == `SWW_KEY);
  assign restartReq = ctrlWrite && keyOk && ctrlData[`SWW_CR_RESTART];
  assign inWindow = (countValue <= deltaLimit) || (deltaLimit >= reloadValue);
  assign winError = restartReq && !inWindow;
  assign halted = modeReg[`SWW_MR_OFF]
    || (debugState && modeReg[`SWW_MR_DBG])
    || (idleState && modeReg[`SWW_MR_IDLE]);
  assign tick = slowTick && !halted && (prescale == 7'(`SWW_PRESCALE - 1));
  assign underflow = tick && (countValue == '0);

  // ----------------------------------------
  // Mode register, written once per processor reset
  // ----------------------------------------
  // The disabled power-on value keeps a fresh part quiet until software arms it.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      modeReg <= `SWW_MODE_RST;
      modeTaken <= 1'b0;
    end
    else if (procRst)
    begin
      modeReg <= `SWW_MODE_RST;
      modeTaken <= 1'b0;
    end
    else if (modeWrite && !modeTaken)
    begin
      modeReg <= modeData;
      modeTaken <= 1'b1;
    end
  end

  // ----------------------------------------
  // Prescaler and counter
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      prescale <= '0;
    else if (procRst || restartReq || (modeWrite && !modeTaken))
      prescale <= '0;
    else if (slowTick && !halted)
      prescale <= prescale + 7'h01;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      countValue <= `SWW_RELOAD_RST;
    else if (procRst)
      countValue <= `SWW_RELOAD_RST;
    else if (modeWrite && !modeTaken)
      countValue <= modeData[`SWW_MR_RELOAD_LSB +: CNT_W];
    else if (restartReq && inWindow)
      countValue <= reloadValue;
    else if (tick && countValue != '0)
      countValue <= countValue - 12'h001;
  end

  // ----------------------------------------
  // Status flags and fault
  // ----------------------------------------
  // A new event in the read cycle wins, so no fault slips past software.
  always_comb
  begin
    next_status = statusRead ? 2'b00 : statusReg;
    if (underflow)
      next_status[0] = 1'b1;
    if (winError)
      next_status[1] = 1'b1;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      statusReg <= 2'b00;
    else if (procRst)
      statusReg <= 2'b00;
    else
      statusReg <= next_status;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      faultIrq <= 1'b0;
      fault_to_reset_ctrl <= 1'b0;
      resetKind <= sww_pkg::SWW_RST_NONE;
    end
    else if (procRst)
    begin
      faultIrq <= 1'b0;
      fault_to_reset_ctrl <= 1'b0;
      resetKind <= sww_pkg::SWW_RST_NONE;
    end
    else
    begin
      faultIrq <= (next_status != 2'b00) && modeReg[`SWW_MR_FIEN];
      fault_to_reset_ctrl <= winError || (underflow && modeReg[`SWW_MR_RSTEN])
        || (fault_to_reset_ctrl && !statusRead);
      if (winError || (underflow && modeReg[`SWW_MR_RSTEN]))
        resetKind <= !modeReg[`SWW_MR_RSTEN] ? sww_pkg::SWW_RST_NONE
          : modeReg[`SWW_MR_PROC] ? sww_pkg::SWW_RST_PROC
          : sww_pkg::SWW_RST_ALL;
      else if (statusRead)
        resetKind <= sww_pkg::SWW_RST_NONE;
    end
  end

  // ----------------------------------------
  // Clock source choice
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      useSlowRc <= 1'b1;
      useMainRc <= 1'b0;
    end
    else
    begin
      useSlowRc <= !main_rc_on && (crystal_select || primaryOff);
      useMainRc <= !(!main_rc_on && (crystal_select || primaryOff));
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence sKeyedRestart;
    restartReq && inWindow && !procRst && !(modeWrite && !modeTaken);
  endsequence

  sequence sFirstModeWrite;
    modeWrite && !modeTaken && !procRst;
  endsequence

  sequence sPlainTick;
    tick && countValue != '0 && !procRst && !restartReq && !(modeWrite && !modeTaken);
  endsequence

  sequence sDebugFreeze;
    debugState && modeReg[`SWW_MR_DBG] && !restartReq && !modeWrite && !procRst;
  endsequence

  sequence sIdleFreeze;
    idleState && modeReg[`SWW_MR_IDLE] && !restartReq && !modeWrite && !procRst;
  endsequence

  AST_RESTART_RELOADS: assert property (@(posedge mclk) disable iff (!arst_n)
    sKeyedRestart |=> countValue == $past(reloadValue) && prescale == '0)
    else $error("Restart did not reload counter and prescaler.");
  AST_BAD_KEY: assert property (@(posedge mclk) disable iff (!arst_n)
    ctrlWrite && !keyOk && !modeWrite && !tick && !procRst |=> $stable(countValue))
    else $error("Wrong key changed the counter.");
  AST_WIN_ERR: assert property (@(posedge mclk) disable iff (!arst_n)
    winError && !procRst |=> statusReg[1] && fault_to_reset_ctrl)
    else $error("Early restart raised no window error.");
  AST_UNDERFLOW: assert property (@(posedge mclk) disable iff (!arst_n)
    underflow && !procRst |=> statusReg[0])
    else $error("Underflow flag not set.");
  AST_ONCE: assert property (@(posedge mclk) disable iff (!arst_n)
    modeTaken && !procRst |=> $stable(modeReg))
    else $error("Mode register changed after first write.");
  AST_READ_CLEAR: assert property (@(posedge mclk) disable iff (!arst_n)
    statusRead && !underflow && !winError |=> statusReg == 2'b00 && !fault_to_reset_ctrl)
    else $error("Status read did not clear flags.");
  AST_OFF_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
    modeReg[`SWW_MR_OFF] && !restartReq && !modeWrite && !procRst |=> $stable(countValue))
    else $error("Counter moved while disabled.");
  AST_IRQ: assert property (@(posedge mclk) disable iff (!arst_n)
    statusReg != 2'b00 && modeReg[`SWW_MR_FIEN] && !$past(statusRead) |-> faultIrq)
    else $error("Interrupt missing for a set flag.");
  AST_PROC_RST: assert property (@(posedge mclk) disable iff (!arst_n)
    procRst |=> modeReg == `SWW_MODE_RST && countValue == `SWW_RELOAD_RST)
    else $error("Processor reset did not restore defaults.");
  AST_KIND: assert property (@(posedge mclk) disable iff (!arst_n)
    winError && !procRst && modeReg[`SWW_MR_RSTEN] && modeReg[`SWW_MR_PROC] |=> resetKind == sww_pkg::SWW_RST_PROC)
    else $error("Wrong reset kind.");
  AST_MODE_LOAD: assert property (@(posedge mclk) disable iff (!arst_n)
    sFirstModeWrite |=> modeTaken && countValue == $past(modeData[`SWW_MR_RELOAD_LSB +: CNT_W]) && prescale == '0)
    else $error("First mode write did not reload the counter.");
  AST_MODE_TAKE: assert property (@(posedge mclk) disable iff (!arst_n)
    sFirstModeWrite |=> modeReg == $past(modeData))
    else $error("First mode write was not taken.");
  AST_TICK_STEP: assert property (@(posedge mclk) disable iff (!arst_n)
    sPlainTick |=> countValue == $past(countValue) - 12'h001)
    else $error("Counter did not step down on a divided tick.");
  AST_DBG_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
    sDebugFreeze |=> $stable(countValue) && $stable(prescale))
    else $error("Counter moved during debug halt.");
  AST_IDLE_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
    sIdleFreeze |=> $stable(countValue) && $stable(prescale))
    else $error("Counter moved during idle halt.");
  AST_UNF_STAY: assert property (@(posedge mclk) disable iff (!arst_n)
    underflow && !restartReq && !modeWrite && !procRst |=> countValue == '0)
    else $error("Counter reloaded itself after underflow.");
  AST_UNF_FAULT: assert property (@(posedge mclk) disable iff (!arst_n)
    underflow && modeReg[`SWW_MR_RSTEN] && !procRst |=> fault_to_reset_ctrl)
    else $error("Underflow raised no fault.");
  AST_WIDE_WINDOW: assert property (@(posedge mclk) disable iff (!arst_n)
    restartReq && deltaLimit >= reloadValue && !statusReg[1] && !procRst |=> !statusReg[1])
    else $error("Restart in an open window raised an error.");
  AST_FLAGS_STAND: assert property (@(posedge mclk) disable iff (!arst_n)
    !statusRead && !procRst |=> (statusReg & $past(statusReg)) == $past(statusReg))
    else $error("A status flag dropped without a read.");
  AST_FAULT_STANDS: assert property (@(posedge mclk) disable iff (!arst_n)
    fault_to_reset_ctrl && !statusRead && !procRst |=> fault_to_reset_ctrl)
    else $error("Fault dropped without a read.");
  AST_IRQ_CLEAR: assert property (@(posedge mclk) disable iff (!arst_n)
    statusRead && !underflow && !winError && !procRst |=> !faultIrq)
    else $error("Status read did not drop the interrupt.");
  AST_KIND_ALL: assert property (@(posedge mclk) disable iff (!arst_n)
    (winError || underflow) && modeReg[`SWW_MR_RSTEN] && !modeReg[`SWW_MR_PROC] && !procRst
    |=> resetKind == sww_pkg::SWW_RST_ALL)
    else $error("Fault did not request a full reset.");
  AST_KIND_TWO: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(fault_to_reset_ctrl) && modeReg[`SWW_MR_RSTEN]
    |-> resetKind == sww_pkg::SWW_RST_ALL || resetKind == sww_pkg::SWW_RST_PROC)
    else $error("Fault requested an unknown reset kind.");
  AST_CLK_MAIN: assert property (@(posedge mclk) disable iff (!arst_n)
    main_rc_on |=> !useSlowRc && useMainRc)
    else $error("Main oscillator in use but slow source chosen.");
  AST_CLK_SLOW: assert property (@(posedge mclk) disable iff (!arst_n)
    !main_rc_on && crystal_select |=> useSlowRc && !useMainRc)
    else $error("Slow oscillator not chosen.");

endmodule // sww_watchdog
`default_nettype wire

/* File: verilog/sww_map.svh */
// Constants of the secondary window watchdog: field positions, reset values, key.
// Assumes inclusion by bare name from the design file.
`ifndef SWW_MAP_SVH
`define SWW_MAP_SVH
`define SWW_CNT_W 12
`define SWW_PRESCALE 128
`define SWW_PRE_W 7
`define SWW_KEY 8'hC4
`define SWW_RELOAD_RST 12'hFFF
`define SWW_DELTA_RST 12'hFFF
`define SWW_MODE_RST 32'h3FFF_AFFF
`define SWW_MR_RELOAD_LSB 0
`define SWW_MR_FIEN 12
`define SWW_MR_RSTEN 13
`define SWW_MR_PROC 14
`define SWW_MR_OFF 15
`define SWW_MR_DELTA_LSB 16
`define SWW_MR_DBG 28
`define SWW_MR_IDLE 29
`define SWW_CR_RESTART 0
`define SWW_CR_KEY_LSB 24
`endif

/* File: verilog/sww_pkg.sv */
// Types shared by the secondary window watchdog.
// Assumes nothing of its surroundings.
`default_nettype none
package sww_pkg;
  typedef logic [11:0] sww_count_t;
  typedef enum logic [1:0] {
    SWW_RST_NONE = 2'b00,
    SWW_RST_ALL = 2'b01,
    SWW_RST_PROC = 2'b10
  } sww_rstkind_e;
endpackage
`default_nettype wire

/* File: verification/sww_partner_model.sv */
// Far side of the watchdog: a free-running slow tick source and a reset controller.
// Assumes the watchdog samples slowTick and procRst on rising mclk edges.
`timescale 1ns/100ps
`default_nettype none
module sww_partner_model
#(
  parameter int TICK_DIV = 4
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic honour,
  input wire logic fault_to_reset_ctrl,
  output logic slowTick,
  output logic procRst
);
  int divCount;
  // The slow clock runs free, so ticks keep arriving between restarts.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      divCount <= 0;
      slowTick <= 1'b0;
    end
    else
    begin
      divCount <= (divCount == TICK_DIV - 1) ? 0 : divCount + 1;
      slowTick <= (divCount == TICK_DIV - 1);
    end
  end
  // A honoured fault becomes a one-cycle processor reset.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      procRst <= 1'b0;
    else
      procRst <= honour && fault_to_reset_ctrl && !procRst;
  end
endmodule // sww_partner_model
`default_nettype wire

/* File: verification/secondary_window_watchdog_test.sv */
// Self-checking bench of the secondary window watchdog.
// Assumes a tick every four mclk cycles from the partner model.
`timescale 1ns/100ps
`default_nettype none
module secondary_window_watchdog_test;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic procRst, slowTick, honour = 1'b0;
  logic ctrlWrite = 1'b0, modeWrite = 1'b0, statusRead = 1'b0;
  logic [31:0] ctrlData = 32'h0, modeData = 32'h0, modeReg;
  logic debugState = 1'b0, idleState = 1'b0, main_rc_on = 1'b0, crystal_select = 1'b1, primaryOff = 1'b0;
  logic [1:0] statusReg, resetKind;
  logic [11:0] countValue;
  logic faultIrq, fault_to_reset_ctrl, useSlowRc, useMainRc;
  int fails = 0;
  int comparisons = 0;
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  sww_partner_model sww_partner_model_inst (.mclk(mclk), .arst_n(arst_n), .honour(honour),
    .fault_to_reset_ctrl(fault_to_reset_ctrl), .slowTick(slowTick), .procRst(procRst));
  sww_watchdog sww_watchdog_inst (.mclk(mclk), .arst_n(arst_n), .procRst(procRst), .slowTick(slowTick),
    .ctrlWrite(ctrlWrite), .ctrlData(ctrlData), .modeWrite(modeWrite), .modeData(modeData),
    .statusRead(statusRead), .debugState(debugState), .idleState(idleState), .main_rc_on(main_rc_on),
    .crystal_select(crystal_select), .primaryOff(primaryOff), .modeReg(modeReg), .statusReg(statusReg),
    .countValue(countValue), .faultIrq(faultIrq), .fault_to_reset_ctrl(fault_to_reset_ctrl),
    .resetKind(resetKind), .useSlowRc(useSlowRc), .useMainRc(useMainRc));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobes rise at a falling edge and fall at the next one: one sampled edge each.
  task automatic pulse(input int k, input logic [31:0] d);
    @(negedge mclk);
    ctrlWrite = (k == 0);
    modeWrite = (k == 1);
    statusRead = (k == 2);
    ctrlData = d;
    modeData = d;
    @(negedge mclk);
    {ctrlWrite, modeWrite, statusRead} = 3'b000;
  endtask
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    fails++;
    summarize();
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    check(modeReg, 32'h3FFF_AFFF);
    check(countValue, 12'hFFF);
    check(statusReg, 2'h0);
    check(useSlowRc, 1'b1);
    check(useMainRc, 1'b0);
    repeat (600) @(negedge mclk);
    check(countValue, 12'hFFF);
    main_rc_on = 1'b1;
    repeat (3) @(negedge mclk);
    check(useSlowRc, 1'b0);
    check(useMainRc, 1'b1);
    $display("test reset done");
    pulse(1, 32'h1001_7003);
    check(modeReg, 32'h1001_7003);
    check(countValue, 12'h003);
    pulse(1, 32'h0000_0FFF);
    check(modeReg, 32'h1001_7003);
    debugState = 1'b1;
    repeat (600) @(negedge mclk);
    check(countValue, 12'h003);
    debugState = 1'b0;
    repeat (600) @(negedge mclk);
    check(countValue, 12'h002);
    $display("test mode done");
    pulse(0, 32'hC500_0001);
    check(statusReg, 2'h0);
    check(countValue, 12'h002);
    pulse(0, 32'hC400_0001);
    check(statusReg, 2'h2);
    check(fault_to_reset_ctrl, 1'b1);
    check(faultIrq, 1'b1);
    check(resetKind, 2'h2);
    pulse(2, 32'h0);
    check(statusReg, 2'h0);
    check(fault_to_reset_ctrl, 1'b0);
    check(faultIrq, 1'b0);
    $display("test window done");
    repeat (2200) @(negedge mclk);
    check(statusReg, 2'h1);
    check(countValue, 12'h000);
    check(fault_to_reset_ctrl, 1'b1);
    honour = 1'b1;
    repeat (10) @(negedge mclk);
    check(modeReg, 32'h3FFF_AFFF);
    check(statusReg, 2'h0);
    $display("test underflow done");
    honour = 1'b0;
    pulse(0, 32'hC400_0001);
    check(statusReg, 2'h0);
    check(fault_to_reset_ctrl, 1'b0);
    check(countValue, 12'hFFF);
    pulse(1, 32'h2001_2003);
    check(countValue, 12'h003);
    pulse(0, 32'hC400_0001);
    check(statusReg, 2'h2);
    check(resetKind, 2'h1);
    check(faultIrq, 1'b0);
    pulse(2, 32'h0);
    check(resetKind, 2'h0);
    idleState = 1'b1;
    repeat (600) @(negedge mclk);
    check(countValue, 12'h003);
    idleState = 1'b0;
    repeat (1100) @(negedge mclk);
    check(countValue, 12'h001);
    pulse(0, 32'hC400_0001);
    check(countValue, 12'h003);
    check(statusReg, 2'h0);
    $display("test second mode done");
    summarize();
  end
endmodule // secondary_window_watchdog_test
`default_nettype wire
